// ### include/acsi_pkg.sv
// constants shared by the converter control block
package acsi_pkg;
    // serial access framing
    localparam int unsigned ACSI_ACCESS_BITS    = 16;
    localparam int unsigned ACSI_BYTE_BITS      = 8;
    localparam int unsigned ACSI_CMD_DIR_POS    = 7;
    localparam int unsigned ACSI_CMD_ADDR_MSB   = 1;
    localparam logic        ACSI_DIR_READ       = 1'b1;
    localparam logic        ACSI_DIR_WRITE      = 1'b0;

    // serial register addresses
    localparam logic [1:0]  ACSI_SADDR_CTRL     = 2'h0;
    localparam logic [1:0]  ACSI_SADDR_PAT_HI   = 2'h1;
    localparam logic [1:0]  ACSI_SADDR_PAT_LO   = 2'h2;
    localparam logic [1:0]  ACSI_SADDR_RESET    = 2'h0;

    // control register fields
    localparam int unsigned ACSI_CTRL_MODE_LSB  = 6;
    localparam int unsigned ACSI_CTRL_LANE      = 5;
    localparam int unsigned ACSI_CTRL_DCS       = 4;
    localparam int unsigned ACSI_CTRL_TWOS      = 3;
    localparam int unsigned ACSI_CTRL_WAM       = 2;
    localparam int unsigned ACSI_CTRL_PDA       = 1;
    localparam int unsigned ACSI_CTRL_PDB       = 0;
    localparam logic [7:0]  ACSI_CTRL_RESET     = 8'h08;
    localparam logic [7:0]  ACSI_PAT_RESET      = 8'h00;
    localparam logic [7:0]  ACSI_PAT_HI_MASK    = 8'h3F;

    // operational modes
    localparam logic [1:0]  ACSI_MODE_NORMAL    = 2'h0;
    localparam logic [1:0]  ACSI_MODE_FIXED     = 2'h1;
    localparam logic [1:0]  ACSI_MODE_USER      = 2'h2;
    localparam logic [13:0] ACSI_FIXED_PATTERN  = 14'h298E;

    // four-level format pin, coded low to high supply level
    localparam logic [1:0]  ACSI_FMT_OB_NODCS   = 2'h0;
    localparam logic [1:0]  ACSI_FMT_OB_DCS     = 2'h1;
    localparam logic [1:0]  ACSI_FMT_2C_DCS     = 2'h2;
    localparam logic [1:0]  ACSI_FMT_2C_NODCS   = 2'h3;

    // bus register byte offsets
    localparam int unsigned ACSI_AHB_ADDR_W     = 8;
    localparam logic [7:0]  ACSI_OFS_CTRL       = 8'h00;
    localparam logic [7:0]  ACSI_OFS_PAT_HI     = 8'h04;
    localparam logic [7:0]  ACSI_OFS_PAT_LO     = 8'h08;
    localparam logic [7:0]  ACSI_OFS_STATUS     = 8'h0C;
    localparam logic [1:0]  ACSI_HTRANS_NONSEQ  = 2'h2;
    localparam logic [2:0]  ACSI_HSIZE_WORD     = 3'h2;

    // status register fields
    localparam int unsigned ACSI_ST_EFF_LSB     = 0;
    localparam int unsigned ACSI_ST_MODE_LSB    = 8;
    localparam int unsigned ACSI_ST_SPI_EN      = 10;
    localparam int unsigned ACSI_ST_LOCK        = 11;
    localparam int unsigned ACSI_ST_OVR_A       = 12;
    localparam int unsigned ACSI_ST_OVR_B       = 13;
    localparam int unsigned ACSI_ST_ADDR_LSB    = 14;

    // timing
    localparam int unsigned ACSI_CLK_HZ         = 10_000_000;
    localparam int unsigned ACSI_LOOP_RST_NS    = 1000;
    localparam int unsigned ACSI_RELOCK_NS      = 5000;
    localparam int unsigned ACSI_LOOP_RST_CYC   =
        (ACSI_LOOP_RST_NS * (ACSI_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned ACSI_RELOCK_CYC     =
        (ACSI_RELOCK_NS * (ACSI_CLK_HZ / 1_000_000) + 999) / 1000;

    typedef enum logic [1:0] {
        ACSI_LK_LOCKED,
        ACSI_LK_LOST,
        ACSI_LK_RESETTING,
        ACSI_LK_RELOCKING
    } acsi_lock_t;
endpackage : acsi_pkg

// ### rtl/acsi_sync.sv
// two-stage synchroniser for a group of pins
`timescale 1ns/1ns
module acsi_sync #(
    parameter int unsigned    WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // pins in, synchronised out
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    if (WIDTH < 1) begin : g_width_check
        $error("acsi_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_reg <= RESET_VAL;
            q        <= RESET_VAL;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : acsi_sync

// ### rtl/acsi_top.sv
// converter control logic: serial register port, direct pins, loop lock, overrange
//
// Summary of operation
// - select high: serial port on, pins ignored
// - each access is exactly sixteen clocks
// - sample input rising, change output falling
// - select assertion starts access; release after sixteenth
// - early release discards access entirely
// - select rising edge latches address, writes
// - direction one reads, zero writes
// - address selects one of three registers
// - read ignores data byte, no writes
// - output driven only while select asserted
// - addressed register shifted out, second byte
// - address pointer resets to zero
// - each channel power-down independent, data corrupt
// - lock high when locked, low when lost
// - lane pin one single lane, zero dual
// - test pin forces fixed fourteen-bit pattern
// - align pin offsets or aligns dual lanes
// - overrange per channel, refreshed per frame
// - control register layout, reset 08h
// - mode codes normal, fixed, user, reserved
// - user pattern split over two registers
// - format pin picks format and stabilizer
`timescale 1ns/1ns
module acsi_top #(
    parameter int unsigned RELOCK_CYC  = acsi_pkg::ACSI_RELOCK_CYC,
    parameter int unsigned LOOP_RST_CYC = acsi_pkg::ACSI_LOOP_RST_CYC
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // register bus
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // serial register port pins
    input  wire logic        serial_port_enable,
    input  wire logic        serial_select_n,
    input  wire logic        serial_clk,
    input  wire logic        serial_in,
    output logic             serial_out,
    output logic             serial_out_oe,
    // direct control pins
    input  wire logic        chan_a_powerdown,
    input  wire logic        chan_b_powerdown,
    input  wire logic        lane_config,
    input  wire logic        word_align_select,
    input  wire logic        test_pattern_pin,
    input  wire logic [1:0]  format_stabilizer_pin,
    // loop reset and lock
    input  wire logic        loop_reset,
    input  wire logic        clock_disturbed,
    output logic             loop_lock,
    // converter core data
    input  wire logic        frame_strobe,
    input  wire logic [13:0] chan_a_sample,
    input  wire logic [13:0] chan_b_sample,
    input  wire logic        chan_a_over_hi,
    input  wire logic        chan_a_over_lo,
    input  wire logic        chan_b_over_hi,
    input  wire logic        chan_b_over_lo,
    // effective configuration and data
    output logic             eff_chan_a_pd,
    output logic             eff_chan_b_pd,
    output logic             eff_single_lane,
    output logic             eff_word_aligned,
    output logic             eff_duty_stabilizer,
    output logic             eff_twos_complement,
    output logic             lane0_enable,
    output logic      [13:0] chan_a_word,
    output logic      [13:0] chan_b_word,
    output logic             chan_a_word_valid,
    output logic             chan_b_word_valid,
    output logic             chan_a_overrange,
    output logic             chan_b_overrange
);
    import acsi_pkg::*;

    if (RELOCK_CYC < 1 || RELOCK_CYC > 65535 ||
        LOOP_RST_CYC < 1 || LOOP_RST_CYC > 65535)
        $error("acsi_top: counts must be 1 to 65535");

    // pin synchronisers
    logic [11:0] pins_q;
    logic        spi_en_s, cs_n_s, sclk_s, sdi_s, pda_s, pdb_s, lane_s, wam_s, test_s;
    logic [1:0]  fmt_s;
    logic        loop_rst_s;

    acsi_sync #(.WIDTH(12), .RESET_VAL(12'h001)) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .d        ({serial_port_enable, serial_clk, serial_in, chan_a_powerdown,
                    chan_b_powerdown, lane_config, word_align_select, test_pattern_pin,
                    format_stabilizer_pin, loop_reset, serial_select_n}),
        .q        (pins_q)
    );
    assign {spi_en_s, sclk_s, sdi_s, pda_s, pdb_s, lane_s, wam_s, test_s,
            fmt_s, loop_rst_s, cs_n_s} = pins_q;

    // registers
    logic [7:0]  ctrl_reg, pat_hi_reg, pat_lo_reg;
    logic [1:0]  addr_ptr_reg;

    // serial engine
    logic        sclk_d_reg, cs_n_d_reg;
    logic [4:0]  rise_cnt_reg, fall_cnt_reg;
    logic [15:0] shift_in_reg;
    logic [7:0]  shift_out_reg;
    logic        sout_reg;
    logic        sclk_rise, sclk_fall, cs_start, cs_end, active;
    logic        commit, ser_wr;
    logic [1:0]  ser_addr;
    logic [7:0]  ser_data;
    logic [7:0]  ser_rd_data;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sclk_d_reg <= 1'b0;
            cs_n_d_reg <= 1'b1;
        end else begin
            sclk_d_reg <= sclk_s;
            cs_n_d_reg <= cs_n_s;
        end
    end

    assign active    = spi_en_s & ~cs_n_s;
    assign sclk_rise = active & sclk_s & ~sclk_d_reg;
    assign sclk_fall = active & ~sclk_s & sclk_d_reg;
    assign cs_start  = ~cs_n_s & cs_n_d_reg;
    assign cs_end    = cs_n_s & ~cs_n_d_reg;
    assign commit    = spi_en_s & cs_end &
                       (rise_cnt_reg == 5'(ACSI_ACCESS_BITS));
    assign ser_addr  = shift_in_reg[ACSI_BYTE_BITS + ACSI_CMD_ADDR_MSB -: 2];
    assign ser_data  = shift_in_reg[ACSI_BYTE_BITS-1:0];
    assign ser_wr    = commit &&
        (shift_in_reg[ACSI_BYTE_BITS + ACSI_CMD_DIR_POS] == ACSI_DIR_WRITE);

    always_comb begin
        unique case (shift_in_reg[ACSI_CMD_ADDR_MSB:0])
            ACSI_SADDR_CTRL:   ser_rd_data = ctrl_reg;
            ACSI_SADDR_PAT_HI: ser_rd_data = pat_hi_reg;
            ACSI_SADDR_PAT_LO: ser_rd_data = pat_lo_reg;
            default:           ser_rd_data = 8'h00;
        endcase
    end

    // bit counters and input shifter; select assertion restarts
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rise_cnt_reg <= 5'h00;
            shift_in_reg <= 16'h0000;
        end else if (cs_start) begin
            rise_cnt_reg <= 5'h00;
            shift_in_reg <= 16'h0000;
        end else if (sclk_rise) begin
            if (rise_cnt_reg <= 5'(ACSI_ACCESS_BITS))
                rise_cnt_reg <= rise_cnt_reg + 5'h01;
            shift_in_reg <= {shift_in_reg[14:0], sdi_s};
        end
    end

    // output shifter: loaded after the command byte, shifted on falling edges
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fall_cnt_reg  <= 5'h00;
            shift_out_reg <= 8'h00;
            sout_reg      <= 1'b0;
        end else if (cs_start) begin
            fall_cnt_reg  <= 5'h00;
            sout_reg      <= 1'b0;
        end else begin
            if (sclk_fall && fall_cnt_reg == 5'(ACSI_BYTE_BITS - 1))
                shift_out_reg <= ser_rd_data;
            if (sclk_fall) begin
                if (fall_cnt_reg <= 5'(ACSI_ACCESS_BITS))
                    fall_cnt_reg <= fall_cnt_reg + 5'h01;
                if (fall_cnt_reg >= 5'(ACSI_BYTE_BITS) &&
                    fall_cnt_reg < 5'(ACSI_ACCESS_BITS)) begin
                    sout_reg      <= shift_out_reg[7];
                    shift_out_reg <= {shift_out_reg[6:0], 1'b0};
                end
            end
        end
    end

    assign serial_out    = sout_reg;
    assign serial_out_oe = active;

    // bus slave
    logic        bus_wr_reg, bus_wr_pend;
    logic [7:0]  bus_ofs_reg;
    logic [31:0] status_word, bus_rd_data;
    logic        bus_take;
    logic [7:0]  eff_cfg;
    logic [1:0]  eff_mode;

    assign bus_take  = hsel & hready & (htrans == ACSI_HTRANS_NONSEQ);
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ACSI_ST_EFF_LSB +: 8]  = eff_cfg;
        status_word[ACSI_ST_MODE_LSB +: 2] = eff_mode;
        status_word[ACSI_ST_SPI_EN]        = spi_en_s;
        status_word[ACSI_ST_LOCK]          = loop_lock;
        status_word[ACSI_ST_OVR_A]         = chan_a_overrange;
        status_word[ACSI_ST_OVR_B]         = chan_b_overrange;
        status_word[ACSI_ST_ADDR_LSB +: 2] = addr_ptr_reg;
        unique case (haddr[ACSI_AHB_ADDR_W-1:0])
            ACSI_OFS_CTRL:   bus_rd_data = {24'h000000, ctrl_reg};
            ACSI_OFS_PAT_HI: bus_rd_data = {24'h000000, pat_hi_reg};
            ACSI_OFS_PAT_LO: bus_rd_data = {24'h000000, pat_lo_reg};
            ACSI_OFS_STATUS: bus_rd_data = status_word;
            default:         bus_rd_data = 32'h0000_0000;
        endcase
    end

    assign bus_wr_pend = bus_take & hwrite & (hsize == ACSI_HSIZE_WORD) &
                         (haddr[31:ACSI_AHB_ADDR_W] == 24'h000000);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus_wr_reg  <= 1'b0;
            bus_ofs_reg <= 8'h00;
            hrdata      <= 32'h0000_0000;
        end else begin
            if (hready) begin
                bus_wr_reg  <= bus_wr_pend;
                bus_ofs_reg <= haddr[ACSI_AHB_ADDR_W-1:0];
            end
            if (bus_take && !hwrite)
                hrdata <= (haddr[31:ACSI_AHB_ADDR_W] == 24'h000000) ? bus_rd_data
                                                                    : 32'h0000_0000;
        end
    end

    // register file: serial commit has priority over a bus write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg   <= ACSI_CTRL_RESET;
            pat_hi_reg <= ACSI_PAT_RESET;
            pat_lo_reg <= ACSI_PAT_RESET;
        end else if (ser_wr) begin
            unique case (ser_addr)
                ACSI_SADDR_CTRL:   ctrl_reg   <= ser_data;
                ACSI_SADDR_PAT_HI: pat_hi_reg <= ser_data & ACSI_PAT_HI_MASK;
                ACSI_SADDR_PAT_LO: pat_lo_reg <= ser_data;
                default:           ;
            endcase
        end else if (bus_wr_reg) begin
            unique case (bus_ofs_reg)
                ACSI_OFS_CTRL:   ctrl_reg   <= hwdata[7:0];
                ACSI_OFS_PAT_HI: pat_hi_reg <= hwdata[7:0] & ACSI_PAT_HI_MASK;
                ACSI_OFS_PAT_LO: pat_lo_reg <= hwdata[7:0];
                default:         ;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            addr_ptr_reg <= ACSI_SADDR_RESET;
        else if (commit)
            addr_ptr_reg <= ser_addr;
    end

    // effective configuration: register when serial port on, else pins
    logic pin_twos, pin_dcs;

    always_comb begin
        unique case (fmt_s)
            ACSI_FMT_OB_NODCS: begin pin_twos = 1'b0; pin_dcs = 1'b0; end
            ACSI_FMT_OB_DCS:   begin pin_twos = 1'b0; pin_dcs = 1'b1; end
            ACSI_FMT_2C_DCS:   begin pin_twos = 1'b1; pin_dcs = 1'b1; end
            default:           begin pin_twos = 1'b1; pin_dcs = 1'b0; end
        endcase
        if (spi_en_s) begin
            eff_mode = ctrl_reg[ACSI_CTRL_MODE_LSB +: 2];
            eff_cfg  = {2'b00, ctrl_reg[5:0]};
        end else begin
            eff_mode = test_s ? ACSI_MODE_FIXED : ACSI_MODE_NORMAL;
            eff_cfg  = 8'h00;
            eff_cfg[ACSI_CTRL_LANE] = lane_s;
            eff_cfg[ACSI_CTRL_DCS]  = pin_dcs;
            eff_cfg[ACSI_CTRL_TWOS] = pin_twos;
            eff_cfg[ACSI_CTRL_WAM]  = wam_s;
            eff_cfg[ACSI_CTRL_PDA]  = pda_s;
            eff_cfg[ACSI_CTRL_PDB]  = pdb_s;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            eff_chan_a_pd       <= 1'b0;
            eff_chan_b_pd       <= 1'b0;
            eff_single_lane     <= 1'b0;
            eff_word_aligned    <= 1'b0;
            eff_duty_stabilizer <= 1'b0;
            eff_twos_complement <= 1'b0;
            lane0_enable        <= 1'b0;
        end else begin
            eff_chan_a_pd       <= eff_cfg[ACSI_CTRL_PDA];
            eff_chan_b_pd       <= eff_cfg[ACSI_CTRL_PDB];
            eff_single_lane     <= eff_cfg[ACSI_CTRL_LANE];
            eff_word_aligned    <= ~eff_cfg[ACSI_CTRL_LANE] &
                                   eff_cfg[ACSI_CTRL_WAM];
            eff_duty_stabilizer <= eff_cfg[ACSI_CTRL_DCS];
            eff_twos_complement <= eff_cfg[ACSI_CTRL_TWOS];
            lane0_enable        <= ~eff_cfg[ACSI_CTRL_LANE];
        end
    end

    // output words and overrange, refreshed once per frame
    function automatic logic [13:0] acsi_word(input logic [13:0] smp,
                                              input logic [1:0]  mode,
                                              input logic        twos,
                                              input logic [13:0] user_pat);
        logic [13:0] w;
        w = 14'h0000;
        unique case (mode)
            ACSI_MODE_FIXED: w = ACSI_FIXED_PATTERN;
            ACSI_MODE_USER:  w = user_pat;
            default:         w = twos ? {~smp[13], smp[12:0]} : smp;
        endcase
        return w;
    endfunction : acsi_word

    logic [13:0] user_pat;
    assign user_pat = {pat_hi_reg[5:0], pat_lo_reg};

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            chan_a_word       <= 14'h0000;
            chan_b_word       <= 14'h0000;
            chan_a_word_valid <= 1'b0;
            chan_b_word_valid <= 1'b0;
            chan_a_overrange  <= 1'b0;
            chan_b_overrange  <= 1'b0;
        end else if (frame_strobe) begin
            chan_a_word <= acsi_word(chan_a_sample, eff_mode,
                                     eff_cfg[ACSI_CTRL_TWOS], user_pat);
            chan_b_word <= acsi_word(chan_b_sample, eff_mode,
                                     eff_cfg[ACSI_CTRL_TWOS], user_pat);
            chan_a_word_valid <= ~eff_cfg[ACSI_CTRL_PDA];
            chan_b_word_valid <= ~eff_cfg[ACSI_CTRL_PDB];
            chan_a_overrange  <= chan_a_over_hi | chan_a_over_lo;
            chan_b_overrange  <= chan_b_over_hi | chan_b_over_lo;
        end
    end

    // loop lock tracking
    acsi_lock_t  lock_state_reg;
    logic [15:0] lock_cnt_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lock_state_reg <= ACSI_LK_RELOCKING;
            lock_cnt_reg   <= 16'h0000;
        end else if (loop_rst_s) begin
            lock_state_reg <= ACSI_LK_RESETTING;
            if (lock_state_reg != ACSI_LK_RESETTING)
                lock_cnt_reg <= 16'h0001;
            else if (lock_cnt_reg != 16'hFFFF)
                lock_cnt_reg <= lock_cnt_reg + 16'h0001;
        end else begin
            unique case (lock_state_reg)
                ACSI_LK_LOCKED: begin
                    if (clock_disturbed)
                        lock_state_reg <= ACSI_LK_LOST;
                end
                ACSI_LK_LOST: ;
                ACSI_LK_RESETTING: begin
                    lock_state_reg <= (lock_cnt_reg >= 16'(LOOP_RST_CYC)) ?
                                      ACSI_LK_RELOCKING : ACSI_LK_LOST;
                    lock_cnt_reg   <= 16'h0000;
                end
                ACSI_LK_RELOCKING: begin
                    if (clock_disturbed) begin
                        lock_state_reg <= ACSI_LK_LOST;
                    end else if (lock_cnt_reg >= 16'(RELOCK_CYC - 1)) begin
                        lock_state_reg <= ACSI_LK_LOCKED;
                    end else begin
                        lock_cnt_reg <= lock_cnt_reg + 16'h0001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            loop_lock <= 1'b0;
        else
            loop_lock <= (lock_state_reg == ACSI_LK_LOCKED);
    end
endmodule : acsi_top

// ### sim/acsi_top_checker.sv
// port assertions for the converter control block
`timescale 1ns/1ns
module acsi_top_checker import acsi_pkg::*; (
    input wire logic core_clk, rst, serial_port_enable, serial_select_n, serial_out_oe,
    input wire logic chan_a_powerdown, lane_config, test_pattern_pin, eff_chan_a_pd,
    input wire logic eff_single_lane, lane0_enable, frame_strobe, loop_lock, clock_disturbed,
    input wire logic chan_a_over_hi, chan_a_over_lo, chan_a_overrange, chan_b_overrange,
    input wire logic chan_a_word_valid,
    input wire logic [13:0] chan_a_word
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_oe_idle: assert property ((serial_select_n || !serial_port_enable)[*3]
        |-> !serial_out_oe) else $error("serial out driven while idle");
    chk_pin_pd: assert property ((!serial_port_enable && chan_a_powerdown)[*5]
        |-> eff_chan_a_pd) else $error("power-down pin not applied");
    chk_pin_lane: assert property ((!serial_port_enable && lane_config)[*5]
        |-> eff_single_lane && !lane0_enable) else $error("lane pin not applied");
    chk_word_valid: assert property (frame_strobe
        |=> chan_a_word_valid == !eff_chan_a_pd) else $error("word valid wrong");
    chk_ovr_frame: assert property (frame_strobe
        |=> chan_a_overrange == $past(chan_a_over_hi || chan_a_over_lo)) else $error("ovr");
    chk_ovr_hold: assert property (!frame_strobe
        |=> $stable(chan_b_overrange)) else $error("overrange moved between frames");
    chk_lock_lost: assert property (clock_disturbed |-> ##2 !loop_lock)
        else $error("lock kept after clock disturbance");
    chk_fixed_pat: assert property ((!serial_port_enable && test_pattern_pin
        && !chan_a_powerdown)[*5] ##0 frame_strobe |=> chan_a_word == ACSI_FIXED_PATTERN)
        else $error("fixed pattern wrong");
endmodule : acsi_top_checker
bind acsi_top acsi_top_checker chk_i (.*);

// ### sim/acsi_host.sv
// serial host model driving the control port
`timescale 1ns/1ns
module acsi_host (
    output logic     sel_n, sclk, sdi,
    input wire logic sdo, sdo_oe
);
    initial {sel_n, sclk, sdi} = 3'b100;
    // core clock keeps running in the bench for the whole run
    task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
        sel_n = 1'b0;
        #400;
        for (int i = 0; i < n; i++) begin
            sdi = w[15 - i];
            #5 sclk = 1'b1;
            #400 sclk = 1'b0;
            #395 rd = {rd[6:0], sdo_oe ? sdo : ~rd[0]};
        end
        sel_n = 1'b1;
        sdi = ~sdi;
        #800;
    endtask : xfer
endmodule : acsi_host

// ### sim/test_acsi_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
module test_acsi_top;
    import acsi_pkg::*;
    logic core_clk = 0, rst = 1, hsel = 0, hwrite = 0, serial_port_enable = 1, loop_reset = 0;
    logic clock_disturbed = 0, frame_strobe = 0, chan_a_powerdown = 0, chan_b_powerdown = 0;
    logic lane_config = 0, word_align_select = 0, test_pattern_pin = 0, chan_a_over_hi = 0;
    logic chan_a_over_lo = 0, chan_b_over_hi = 0, chan_b_over_lo = 0;
    logic [1:0]  htrans = 0, format_stabilizer_pin = 0;
    logic [2:0]  hsize = ACSI_HSIZE_WORD;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r, seed, error_cnt = 0, n_tests = 0;
    logic [13:0] chan_a_sample = 0, chan_b_sample = 0, chan_a_word, chan_b_word, up;
    logic [7:0]  d;
    logic hreadyout, hresp, serial_out, serial_out_oe, loop_lock, eff_chan_a_pd, eff_chan_b_pd;
    logic eff_single_lane, eff_word_aligned, eff_duty_stabilizer, eff_twos_complement;
    logic lane0_enable, chan_a_word_valid, chan_b_word_valid, chan_a_overrange, chan_b_overrange;
    wire logic serial_select_n, serial_clk, serial_in, hready;
    assign hready = hreadyout;
    acsi_top #(.RELOCK_CYC(4), .LOOP_RST_CYC(2)) uut (.*);
    acsi_host h (.sel_n(serial_select_n), .sclk(serial_clk), .sdi(serial_in),
                 .sdo(serial_out), .sdo_oe(serial_out_oe));
    initial forever #50 core_clk = ~core_clk;
    task stop_test;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wt;
        for (int i = 0; i < 50; i++) begin
            @(posedge core_clk);
            if (hready === 1'b1) return;
        end
        error_cnt++;
        stop_test();
    endtask : wt
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, ACSI_HTRANS_NONSEQ, w, 24'h0, a};
        wt();
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
        wt();
        r = hrdata;
    endtask : ahb
    task ser(input logic dir, input logic [1:0] a, input logic [7:0] v, input int n);
        #1 h.xfer({dir, 5'h0, a, v}, n, d);
        repeat (4) @(posedge core_clk);
    endtask : ser
    task frame(input logic [13:0] s);
        @(posedge core_clk);
        {chan_a_over_hi, chan_a_over_lo, chan_b_over_hi, chan_b_over_lo} <= 4'($random(seed));
        {chan_a_sample, chan_b_sample, frame_strobe} <= {s, ~s, 1'b1};
        @(posedge core_clk);
        frame_strobe <= 0;
        #1;
    endtask : frame
    function logic [13:0] exp_word(logic [1:0] m, logic [13:0] s, logic [13:0] u);
        return m == ACSI_MODE_FIXED ? ACSI_FIXED_PATTERN : m == ACSI_MODE_USER ? u : s ^ 14'h2000;
    endfunction : exp_word
    initial begin
        #2_000_000;
        error_cnt++;
        stop_test();
    end
    initial begin
        seed = 32'h695695CA;
        repeat (12) @(posedge core_clk);
        rst <= 0;
        repeat (3) @(posedge core_clk);
        ahb(0, ACSI_OFS_CTRL, 0);
        chk(r, 32'h08);
        ahb(0, ACSI_OFS_STATUS, 0);
        chk(r[15:14], ACSI_SADDR_RESET);
        up = 14'($random(seed));
        ser(ACSI_DIR_WRITE, ACSI_SADDR_PAT_HI, {2'h0, up[13:8]}, 16);
        ser(ACSI_DIR_WRITE, ACSI_SADDR_PAT_LO, up[7:0], 16);
        ser(ACSI_DIR_READ, ACSI_SADDR_PAT_HI, 8'hFF, 16);
        chk(d, up[13:8]);
        ser(ACSI_DIR_WRITE, ACSI_SADDR_PAT_LO, ~up[7:0], 15);
        ser(ACSI_DIR_READ, ACSI_SADDR_PAT_LO, ~up[7:0], 16);
        chk(d, up[7:0]);
        ser(ACSI_DIR_READ, 2'h3, 8'h00, 16);
        chk(d, 0);
        $display("serial access test done");
        for (int m = 0; m < 4; m++) begin
            ser(ACSI_DIR_WRITE, ACSI_SADDR_CTRL, {m[1:0], 6'h08}, 16);
            r = $random(seed);
            frame(r[13:0]);
            chk(chan_a_word, exp_word(m[1:0], r[13:0], up));
            chk(chan_b_word, exp_word(m[1:0], ~r[13:0], up));
        end
        ser(ACSI_DIR_WRITE, ACSI_SADDR_CTRL, 8'h22, 16);
        frame(up);
        chk({eff_single_lane, eff_chan_a_pd, chan_a_word_valid, eff_chan_b_pd, chan_b_word_valid,
             eff_word_aligned, eff_duty_stabilizer, eff_twos_complement}, 8'hC8);
        ahb(1, ACSI_OFS_STATUS, 0);
        ahb(1, 8'h10, 32'hFF);
        ahb(0, 8'h10, 0);
        chk(r, 0);
        ahb(0, ACSI_OFS_STATUS, 0);
        chk(r[7:0], 8'h22);
        ahb(1, ACSI_OFS_CTRL, 32'h40);
        ser(ACSI_DIR_READ, ACSI_SADDR_CTRL, 8'h00, 16);
        chk(d, 8'h40);
        $display("mode test done");
        serial_port_enable <= 0;
        test_pattern_pin <= 1;
        repeat (8) @(posedge core_clk);
        frame(up);
        chk(chan_a_word, ACSI_FIXED_PATTERN);
        {chan_a_powerdown, lane_config, format_stabilizer_pin} <= {2'b11, ACSI_FMT_2C_DCS};
        repeat (8) @(posedge core_clk);
        chk({eff_chan_a_pd, eff_single_lane, eff_twos_complement, eff_duty_stabilizer}, 4'hF);
        clock_disturbed <= 1;
        @(posedge core_clk);
        {clock_disturbed, loop_reset} <= 2'b01;
        repeat (2) @(posedge core_clk);
        chk(loop_lock, 0);
        loop_reset <= 0;
        for (int i = 0; i < 20 && loop_lock !== 1'b1; i++) @(posedge core_clk);
        chk(loop_lock, 1);
        $display("pin and lock test done");
        stop_test();
    end
endmodule : test_acsi_top
